// ### alu_and_skip_branch_unit.sv
// Execution unit: register file, arithmetic and logic, skips, jumps, calls and returns
`timescale 1ns/1ps
`default_nettype none

// Function
// [RQ1] Add two registers, six flags, one cycle
// [RQ2] Add with carry in, six flags, one cycle
// [RQ3] Subtract register or constant, six flags
// [RQ4] Subtract with borrow, register or constant
// [RQ5] AND, OR, XOR; carry kept; one cycle
// [RQ6] OR immediate mask into destination
// [RQ7] AND destination with inverted mask
// [RQ8] Test register against itself, no change
// [RQ9] Compare with constant, flags only
// [RQ10] Skip next when two registers equal
// [RQ11] Skip next when selected bit clear
// [RQ12] Skip next when selected bit set
// [RQ13] Jump to Z pointer, two cycles
// [RQ14] Call Z pointer, push return, three cycles
// [RQ15] Relative jump two, call three cycles
// [RQ16] Returns pop PC in four cycles
module alu_and_skip_branch_unit (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic instr_valid,
    input wire alu_pkg::instr_s instr,
    input wire logic [4:0] peek_sel,
    output logic ready,
    output logic retire,
    output logic [15:0] pc,
    output alu_pkg::flags_s flags,
    output logic [7:0] peek_data
);
    import alu_pkg::*;

    state_s state_reg;
    state_s state_next;
    logic accept;
    logic [15:0] z_ptr;

    // Adder with half carry and signed overflow
    function automatic arith_s add_calc(input logic [7:0] a, input logic [7:0] b, input logic ci);
        arith_s r;
        logic [8:0] full;
        full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        r.res = full[7:0];
        r.c = full[8];
        r.h = (a[3] & b[3]) | (b[3] & ~r.res[3]) | (~r.res[3] & a[3]);
        r.v = (a[7] & b[7] & ~r.res[7]) | (~a[7] & ~b[7] & r.res[7]);
        return r;
    endfunction

    // Subtractor; carry and half carry report a borrow
    function automatic arith_s sub_calc(input logic [7:0] a, input logic [7:0] b, input logic bi);
        arith_s r;
        r.res = 8'(a - b - {7'h00, bi});
        r.c = (~a[7] & b[7]) | (b[7] & r.res[7]) | (r.res[7] & ~a[7]);
        r.h = (~a[3] & b[3]) | (b[3] & r.res[3]) | (r.res[3] & ~a[3]);
        r.v = (a[7] & ~b[7] & ~r.res[7]) | (~a[7] & b[7] & r.res[7]);
        return r;
    endfunction

    // Fills the arithmetic flags; chained borrow keeps Z only if it was already set
    function automatic flags_s arith_flags(input flags_s f, input arith_s r, input logic chain);
        flags_s o;
        o = f;
        o.c = r.c;
        o.h = r.h;
        o.v = r.v;
        o.n = r.res[7];
        o.z = (r.res == DATA_ZERO) & (~chain | f.z);
        o.s = r.res[7] ^ r.v;
        return o;
    endfunction

    // Logic results clear V and leave C and H alone
    function automatic flags_s logic_flags(input flags_s f, input logic [7:0] res);
        flags_s o;
        o = f;
        o.v = 1'b0;
        o.n = res[7];
        o.z = (res == DATA_ZERO);
        o.s = res[7];
        return o;
    endfunction

    assign accept = instr_valid & state_reg.ready;
    assign z_ptr = {state_reg.regs[Z_HIGH_IDX], state_reg.regs[Z_LOW_IDX]};

    // Next state: one instruction is taken only while ready is high
    always_comb begin
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] lres;
        logic [15:0] pc_inc;
        logic [15:0] pc_rel;
        logic [2:0] cyc;
        logic skip;
        arith_s ar;
        a = state_reg.regs[instr.rd];
        b = state_reg.regs[instr.rr];
        lres = DATA_ZERO;
        pc_inc = 16'(state_reg.pc + PC_STEP);
        pc_rel = 16'(state_reg.pc + {{4{instr.offset[11]}}, instr.offset} + PC_STEP);
        cyc = {1'b0, CYC_SINGLE};
        skip = 1'b0;
        ar = '0;
        state_next = state_reg;
        state_next.retire = 1'b0;
        state_next.peek = state_reg.regs[peek_sel];
        // Count down the extra cycles of a multi-cycle instruction
        if (state_reg.wait_cnt != 3'h0) begin
            state_next.wait_cnt = 3'(state_reg.wait_cnt - 3'h1);
            state_next.ready = (state_reg.wait_cnt == 3'h1);
        end
        if (accept) begin
            state_next.retire = 1'b1;
            state_next.pc = pc_inc;
            case (instr.op)
                sum, sum_with_carry: begin
                    ar = add_calc(a, b, (instr.op == sum_with_carry) & state_reg.flags.c); // RQ1 RQ2
                    state_next.regs[instr.rd] = ar.res;
                    state_next.flags = arith_flags(state_reg.flags, ar, 1'b0);
                end
                difference, difference_with_constant: begin
                    ar = sub_calc(a, (instr.op == difference) ? b : instr.k, 1'b0); // RQ3
                    state_next.regs[instr.rd] = ar.res;
                    state_next.flags = arith_flags(state_reg.flags, ar, 1'b0);
                end
                difference_with_borrow, constant_difference_with_borrow: begin
                    ar = sub_calc(a, (instr.op == difference_with_borrow) ? b : instr.k,
                        state_reg.flags.c); // RQ4
                    state_next.regs[instr.rd] = ar.res;
                    state_next.flags = arith_flags(state_reg.flags, ar, 1'b1);
                end
                compare_with_constant: begin
                    // Flags only; the destination keeps its value
                    ar = sub_calc(a, instr.k, 1'b0); // RQ9
                    state_next.flags = arith_flags(state_reg.flags, ar, 1'b0);
                end
                conjunction, mask_with_constant, merge, merge_with_constant, exclusive_merge,
                set_bits_by_mask, clear_bits_by_mask, zero_sign_test: begin
                    case (instr.op)
                        conjunction: lres = a & b; // RQ5
                        mask_with_constant: lres = a & instr.k; // RQ5
                        merge: lres = a | b; // RQ5
                        merge_with_constant: lres = a | instr.k; // RQ5
                        exclusive_merge: lres = a ^ b; // RQ5
                        set_bits_by_mask: lres = a | instr.k; // RQ6
                        clear_bits_by_mask: lres = a & (ALL_ONES - instr.k); // RQ7
                        default: lres = a & a; // RQ8
                    endcase
                    state_next.regs[instr.rd] = lres;
                    state_next.flags = logic_flags(state_reg.flags, lres);
                end
                load_constant: begin
                    // Loads a register so software can seed operands; flags untouched
                    state_next.regs[instr.rd] = instr.k;
                end
                compare_then_skip_equal, skip_when_bit_clear, skip_when_bit_set: begin
                    case (instr.op)
                        compare_then_skip_equal: skip = (a == b); // RQ10
                        skip_when_bit_clear: skip = ~b[instr.bit_sel]; // RQ11
                        default: skip = b[instr.bit_sel]; // RQ12
                    endcase
                    // The skipped word count decides both the PC step and the cycle count
                    if (skip) begin
                        cyc = instr.next_two_words ? {1'b0, CYC_SKIP_TWO} : {1'b0, CYC_SKIP_ONE};
                        state_next.pc = 16'(state_reg.pc + {14'h0000, cyc[1:0]});
                    end
                end
                pointer_jump: begin
                    state_next.pc = z_ptr; // RQ13
                    cyc = {1'b0, CYC_JUMP};
                end
                relative_jump: begin
                    state_next.pc = pc_rel; // RQ15
                    cyc = {1'b0, CYC_JUMP};
                end
                pointer_call, relative_call: begin
                    // Stack wraps silently when more than its depth of calls nest
                    state_next.stack[state_reg.sp] = pc_inc; // RQ14
                    state_next.sp = 3'(state_reg.sp + 3'h1);
                    state_next.pc = (instr.op == pointer_call) ? z_ptr : pc_rel; // RQ14 RQ15
                    cyc = {1'b0, CYC_CALL};
                end
                subroutine_return, return_from_interrupt: begin
                    state_next.sp = 3'(state_reg.sp - 3'h1);
                    state_next.pc = state_reg.stack[3'(state_reg.sp - 3'h1)]; // RQ16
                    if (instr.op == return_from_interrupt) begin
                        state_next.flags.i = 1'b1; // RQ16
                    end
                    cyc = CYC_RETURN;
                end
                default: begin
                    // Unknown codes retire as a one-cycle step
                    state_next.pc = pc_inc;
                end
            endcase
            state_next.wait_cnt = 3'(cyc - 3'h1);
            state_next.ready = (cyc == 3'h1);
        end
    end

    // State register; reset leaves the unit ready with clear flags and registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= '0;
            state_reg.pc <= PC_RESET;
            state_reg.flags <= FLAGS_RESET;
            state_reg.ready <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs come straight from the state flops
    assign ready = state_reg.ready;
    assign retire = state_reg.retire;
    assign pc = state_reg.pc;
    assign flags = state_reg.flags;
    assign peek_data = state_reg.peek;

    // Checks on timing and flag behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_add_zero_carry: assert property (accept && instr.op == sum // RQ1
        && state_reg.regs[instr.rd] == ALL_ONES && state_reg.regs[instr.rr] == 8'h01
        |=> flags.z && flags.c && flags.h && ready) else $error("add flags wrong");
    a_carry_in_used: assert property (accept && instr.op == sum_with_carry // RQ2
        && flags.c && state_reg.regs[instr.rd] == ALL_ONES && state_reg.regs[instr.rr] == DATA_ZERO
        |=> flags.z && flags.c) else $error("carry in ignored");
    a_self_sub_zero: assert property (accept && instr.op == difference // RQ3
        && instr.rd == instr.rr |=> flags.z && !flags.c && !flags.n) else $error("sub flags wrong");
    a_borrow_used: assert property (accept && instr.op == constant_difference_with_borrow // RQ4
        && flags.c && instr.k == DATA_ZERO && state_reg.regs[instr.rd] == DATA_ZERO
        |=> flags.c && flags.n && !flags.z) else $error("borrow ignored");
    a_logic_keeps_c: assert property (accept && (instr.op == conjunction // RQ5
        || instr.op == set_bits_by_mask || instr.op == clear_bits_by_mask
        || instr.op == zero_sign_test) |=> !flags.v && flags.c == $past(flags.c)
        && flags.h == $past(flags.h)) else $error("logic touched carry");
    a_cmp_one_step: assert property (accept && instr.op == compare_with_constant // RQ9
        |=> pc == 16'($past(pc) + PC_STEP) && ready) else $error("compare timing wrong");
    a_skip_two_word: assert property (accept && instr.op == skip_when_bit_set // RQ12
        && state_reg.regs[instr.rr][instr.bit_sel] && instr.next_two_words
        |=> !ready[*2] ##1 ready) else $error("skip cycles wrong");
    a_skip_flags: assert property (accept && (instr.op == compare_then_skip_equal // RQ10
        || instr.op == skip_when_bit_clear) |=> flags == $past(flags)) else $error("skip flags");
    a_ptr_jump: assert property (accept && instr.op == pointer_jump // RQ13
        |=> pc == $past(z_ptr) && !ready ##1 ready) else $error("pointer jump wrong");
    a_call_timing: assert property (accept && instr.op == pointer_call // RQ14
        |=> !ready[*2] ##1 ready) else $error("call cycles wrong");
    a_rel_jump: assert property (accept && instr.op == relative_jump // RQ15
        |=> !ready ##1 ready) else $error("relative jump cycles wrong");
    a_return_from_interrupt_i: assert property (accept && instr.op == return_from_interrupt // RQ16
        |=> flags.i && !ready[*3] ##1 ready) else $error("return wrong");

    c_call_return: cover property (accept && instr.op == relative_call
        ##[3:20] accept && instr.op == subroutine_return);
    c_skip_taken: cover property (accept && instr.op == compare_then_skip_equal
        ##1 !ready ##1 ready);
    c_add_carry: cover property (accept && instr.op == sum_with_carry && flags.c);
endmodule

`default_nettype wire

// ### alu_pkg.sv
// Package: widths, timing counts, flag layout, opcodes and state of the execution unit
`default_nettype none
package alu_pkg;

    // Data path and program counter widths
    localparam int DATA_W = 8;
    localparam int PC_W = 16;
    localparam int REG_COUNT = 32;
    localparam int REG_SEL_W = 5;
    localparam int OFFSET_W = 12;
    localparam int STACK_DEPTH = 8;
    localparam int STACK_PTR_W = 3;

    // Register numbers of the Z pointer pair
    localparam logic [4:0] Z_LOW_IDX = 5'h1E;
    localparam logic [4:0] Z_HIGH_IDX = 5'h1F;

    // Constants used by the data path
    localparam logic [7:0] ALL_ONES = 8'hFF;
    localparam logic [7:0] DATA_ZERO = 8'h00;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] PC_STEP = 16'h0001;

    // Cycle counts per instruction class
    localparam logic [1:0] CYC_SINGLE = 2'h1;
    localparam logic [1:0] CYC_SKIP_ONE = 2'h2;
    localparam logic [1:0] CYC_SKIP_TWO = 2'h3;
    localparam logic [1:0] CYC_JUMP = 2'h2;
    localparam logic [1:0] CYC_CALL = 2'h3;
    localparam logic [2:0] CYC_RETURN = 3'h4;

    // Status flags, most significant first
    typedef struct packed {
        logic i;
        logic t;
        logic h;
        logic s;
        logic v;
        logic n;
        logic z;
        logic c;
    } flags_s;

    localparam flags_s FLAGS_RESET = 8'h00;

    typedef enum logic [4:0] {
        sum = 5'h00,
        sum_with_carry = 5'h01,
        difference = 5'h02,
        difference_with_constant = 5'h03,
        difference_with_borrow = 5'h04,
        constant_difference_with_borrow = 5'h05,
        conjunction = 5'h06,
        mask_with_constant = 5'h07,
        merge = 5'h08,
        merge_with_constant = 5'h09,
        exclusive_merge = 5'h0A,
        set_bits_by_mask = 5'h0B,
        clear_bits_by_mask = 5'h0C,
        zero_sign_test = 5'h0D,
        compare_with_constant = 5'h0E,
        compare_then_skip_equal = 5'h0F,
        skip_when_bit_clear = 5'h10,
        skip_when_bit_set = 5'h11,
        pointer_jump = 5'h12,
        pointer_call = 5'h13,
        relative_jump = 5'h14,
        relative_call = 5'h15,
        subroutine_return = 5'h16,
        return_from_interrupt = 5'h17,
        load_constant = 5'h18
    } op_e;

    // One instruction as presented to the unit
    typedef struct packed {
        op_e op;
        logic [4:0] rd;
        logic [4:0] rr;
        logic [7:0] k;
        logic [2:0] bit_sel;
        logic [11:0] offset;
        logic next_two_words;
    } instr_s;

    // Arithmetic result with its carry-type flags
    typedef struct packed {
        logic [7:0] res;
        logic c;
        logic h;
        logic v;
    } arith_s;

    // Whole state of the unit
    typedef struct packed {
        logic [REG_COUNT-1:0][7:0] regs;
        logic [STACK_DEPTH-1:0][15:0] stack;
        logic [2:0] sp;
        logic [15:0] pc;
        flags_s flags;
        logic [2:0] wait_cnt;
        logic ready;
        logic retire;
        logic [7:0] peek;
    } state_s;

endpackage
`default_nettype wire

// ### tb_top.sv
// Self-checking testbench for the execution unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import alu_pkg::*;
    logic clk;
    logic arst_n;
    logic instr_valid;
    instr_s instr;
    logic [4:0] peek_sel;
    logic ready;
    logic retire;
    logic [15:0] pc;
    flags_s flags;
    logic [7:0] peek_data;
    int mismatches;
    int tests_run;
    int cycles = 0;
    logic [31:0] seed;
    logic [7:0] m_regs [32];
    logic [15:0] m_stack [8];
    int m_sp;
    logic [15:0] m_pc;
    flags_s m_flags;
    logic [15:0] corners [4] = '{16'hFF01, 16'h8001, 16'h7F01, 16'h0F0F};
    instr_s x;

    alu_and_skip_branch_unit dut (.clk(clk), .arst_n(arst_n), .instr_valid(instr_valid),
        .instr(instr), .peek_sel(peek_sel), .ready(ready), .retire(retire), .pc(pc),
        .flags(flags), .peek_data(peek_data));

    // Clock of 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Hang guard, far above the fewer than two thousand cycles the run needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            mismatches = mismatches + 1;
            final_report();
        end
    end

    task automatic final_report();
        if (mismatches == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {1'b0, v[31:1]} ^ (v[0] ? 32'h80200003 : 32'h00000000);
    endfunction

    function automatic arith_s add8(input logic [7:0] a, input logic [7:0] b, input logic ci);
        arith_s r;
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        r.res = s[7:0];
        r.c = s[8];
        r.h = ({1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci}) > 5'h0F;
        r.v = (a[7] == b[7]) && (s[7] != a[7]);
        return r;
    endfunction

    function automatic arith_s sub8(input logic [7:0] a, input logic [7:0] b, input logic ci);
        arith_s r;
        logic [8:0] s;
        s = {1'b0, a} - {1'b0, b} - {8'h00, ci};
        r.res = s[7:0];
        r.c = s[8];
        r.h = {1'b0, a[3:0]} < ({1'b0, b[3:0]} + {4'h0, ci});
        r.v = (a[7] != b[7]) && (s[7] != a[7]);
        return r;
    endfunction

    // Six arithmetic flags; chained forms only keep Z when it was already set
    task automatic arith_op(input logic [4:0] rd, input arith_s r, input logic chain,
        input logic wr);
        m_flags.z = (r.res == 8'h00) && (!chain || m_flags.z);
        m_flags.h = r.h;
        m_flags.v = r.v;
        m_flags.n = r.res[7];
        m_flags.s = r.res[7] ^ r.v;
        m_flags.c = r.c;
        if (wr) m_regs[rd] = r.res;
    endtask

    // Logic ops clear V and leave C and H alone
    task automatic logic_op(input logic [4:0] rd, input logic [7:0] res);
        m_flags.z = (res == 8'h00);
        m_flags.v = 1'b0;
        m_flags.n = res[7];
        m_flags.s = res[7];
        m_regs[rd] = res;
    endtask

    // Reference step: updates the model and gives the cycle count
    task automatic model(input instr_s i, output int n);
        logic [7:0] a;
        logic [7:0] b;
        logic [15:0] nxt;
        logic hit;
        a = m_regs[i.rd];
        b = m_regs[i.rr];
        nxt = m_pc + 16'h0001;
        n = 1;
        hit = 1'b0;
        case (i.op)
            sum: arith_op(i.rd, add8(a, b, 1'b0), 1'b0, 1'b1);
            sum_with_carry: arith_op(i.rd, add8(a, b, m_flags.c), 1'b0, 1'b1);
            difference: arith_op(i.rd, sub8(a, b, 1'b0), 1'b0, 1'b1);
            difference_with_constant: arith_op(i.rd, sub8(a, i.k, 1'b0), 1'b0, 1'b1);
            difference_with_borrow: arith_op(i.rd, sub8(a, b, m_flags.c), 1'b1, 1'b1);
            constant_difference_with_borrow:
                arith_op(i.rd, sub8(a, i.k, m_flags.c), 1'b1, 1'b1);
            compare_with_constant: arith_op(i.rd, sub8(a, i.k, 1'b0), 1'b0, 1'b0);
            conjunction: logic_op(i.rd, a & b);
            mask_with_constant: logic_op(i.rd, a & i.k);
            merge: logic_op(i.rd, a | b);
            merge_with_constant, set_bits_by_mask: logic_op(i.rd, a | i.k);
            exclusive_merge: logic_op(i.rd, a ^ b);
            clear_bits_by_mask: logic_op(i.rd, a & (8'hFF - i.k));
            zero_sign_test: logic_op(i.rd, a);
            compare_then_skip_equal: hit = (a == b);
            skip_when_bit_clear: hit = !b[i.bit_sel];
            skip_when_bit_set: hit = b[i.bit_sel];
            pointer_jump, relative_jump: n = 2;
            pointer_call, relative_call: n = 3;
            subroutine_return, return_from_interrupt: n = 4;
            load_constant: m_regs[i.rd] = i.k;
            default: n = 1;
        endcase
        if (hit) begin
            n = i.next_two_words ? 3 : 2;
            nxt = m_pc + 16'(n);
        end
        if (n == 3 && !hit) begin
            m_stack[m_sp] = m_pc + 16'h0001;
            m_sp++;
        end
        if (i.op inside {pointer_jump, pointer_call}) nxt = {m_regs[31], m_regs[30]};
        if (i.op inside {relative_jump, relative_call}) begin
            nxt = m_pc + {{4{i.offset[11]}}, i.offset} + 16'h0001;
        end
        if (n == 4) begin
            m_sp--;
            nxt = m_stack[m_sp];
        end
        if (i.op == return_from_interrupt) m_flags.i = 1'b1;
        m_pc = nxt;
    endtask

    // Offer one instruction, hold a refused one while busy, then check
    task automatic run(input instr_s i);
        int n;
        int low;
        model(i, n);
        instr = i;
        instr_valid = 1'b1;
        @(negedge clk);
        check("retire", 16'h0001, {15'h0000, retire});
        instr.op = load_constant;
        instr.k = ~m_regs[i.rd];
        low = 0;
        while (1) begin
            instr_valid = (ready === 1'b0);
            if (ready !== 1'b0 || low > 8) break;
            low++;
            @(negedge clk);
        end
        check("busy", 16'(n - 1), 16'(low));
        check("pc", m_pc, pc);
        check("flags", {8'h00, m_flags}, {8'h00, flags});
        peek_sel = i.rd;
        @(negedge clk);
        check("reg", {8'h00, m_regs[i.rd]}, {8'h00, peek_data});
        check("retire", 16'h0000, {15'h0000, retire});
    endtask

    task automatic rand_instr(output instr_s i);
        seed = lfsr_next(seed);
        i = instr_s'({seed, seed[6:0]});
        seed = lfsr_next(seed);
        i.op = op_e'(5'(seed % 25));
        if (m_sp == 0 && i.op inside {subroutine_return, return_from_interrupt}) begin
            i.op = relative_call;
        end
        if (m_sp == 8 && i.op inside {pointer_call, relative_call}) i.op = pointer_jump;
    endtask

    task automatic load(input logic [4:0] rd, input logic [7:0] k);
        rand_instr(x);
        x.op = load_constant;
        x.rd = rd;
        x.k = k;
        run(x);
    endtask

    // Directed step with chosen registers and a zero constant
    task automatic directed(input op_e o, input logic [4:0] rd, input logic [4:0] rr);
        rand_instr(x);
        x.op = o;
        x.rd = rd;
        x.rr = rr;
        x.k = 8'h00;
        run(x);
    endtask

    task automatic model_reset();
        foreach (m_regs[r]) m_regs[r] = 8'h00;
        m_pc = 16'h0000;
        m_flags = 8'h00;
        m_sp = 0;
    endtask

    initial begin
        int n;
        arst_n = 1'b0;
        instr_valid = 1'b0;
        instr = '0;
        peek_sel = 5'h00;
        mismatches = 0;
        tests_run = 0;
        seed = 32'hDBB0;
        model_reset();
        repeat (12) @(negedge clk);
        check("reset", 16'h0200, {6'h00, ready, retire, flags});
        check("reset pc", 16'h0000, pc | {8'h00, peek_data});
        arst_n = 1'b1;
        @(negedge clk);
        // Boundary operand pairs through every arithmetic, logic and skip op
        for (int p = 0; p < 4; p++) begin
            for (int o = 0; o < 18; o++) begin
                load(5'h01, corners[p][15:8]);
                load(5'h02, corners[p][7:0]);
                rand_instr(x);
                x.op = op_e'(o);
                x.rd = 5'h01;
                x.rr = 5'h02;
                run(x);
            end
        end
        // Carry out of an add feeds a carry-in add, then a borrow into a constant subtract
        load(5'h04, 8'hFF);
        load(5'h05, 8'h00);
        load(5'h01, 8'hFF);
        load(5'h02, 8'h01);
        directed(sum, 5'h01, 5'h02);
        directed(sum_with_carry, 5'h04, 5'h05);
        directed(constant_difference_with_borrow, 5'h04, 5'h05);
        directed(difference, 5'h03, 5'h03);
        // Each op once with random fields, plus an unused encoding
        for (int o = 0; o < 26; o++) begin
            rand_instr(x);
            x.op = (o == 25) ? op_e'(5'h1C) : op_e'(o);
            if (m_sp == 0 && o inside {22, 23}) x.op = relative_call;
            run(x);
        end
        for (int r = 0; r < 32; r++) begin
            seed = lfsr_next(seed);
            load(5'(r), seed[7:0]);
        end
        // Random traffic
        repeat (400) begin
            rand_instr(x);
            run(x);
        end
        // Two single-cycle ops with no gap between them
        rand_instr(x);
        x.op = sum;
        model(x, n);
        instr = x;
        instr_valid = 1'b1;
        @(negedge clk);
        x.op = exclusive_merge;
        model(x, n);
        instr = x;
        @(negedge clk);
        instr_valid = 1'b0;
        check("pc", m_pc, pc);
        check("flags", {8'h00, m_flags}, {8'h00, flags});
        // Reset in mid-run acts without waiting for a clock edge
        arst_n = 1'b0;
        #10;
        check("reset pc", 16'h0000, pc);
        @(negedge clk);
        arst_n = 1'b1;
        model_reset();
        @(negedge clk);
        load(5'h03, 8'h7F);
        final_report();
    end
endmodule
`default_nettype wire
